// *** pkg/pse_pkg.sv ***
// Shared constants and types for the PoE controller host-facing control logic.
package pse_pkg;

   // ------------------------------------------------------------
   // Target address layout
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_PREFIX     = 4'h4;  // Fixed upper address bits 0100.
   localparam int         ADDR_PREFIX_LSB = 3;     // Prefix sits above the three strap bits.
   localparam int         ADDR_W          = 7;
   localparam logic [6:0] ADDR_RST        = 7'h20; // Address shown before the first strap capture.

   // ------------------------------------------------------------
   // Ports and timing
   // ------------------------------------------------------------
   localparam int         NUM_PORTS      = 4;
   localparam int         CLK_PERIOD_PS  = 10000;  // 100 MHz system clock.
   localparam int         RESET_MIN_NS   = 10000;  // Least valid low time of the reset input.
   localparam int         RESET_MIN_CYC  = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [3:0] BIT_CNT_RST    = 4'h0;
   localparam logic [3:0] BIT_CNT_LAST   = 4'h7;   // Eighth bit of the address byte.

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      PSE_TGT_IDLE = 4'b0001,
      PSE_TGT_ADDR = 4'b0010,
      PSE_TGT_ACK  = 4'b0100,
      PSE_TGT_HOLD = 4'b1000
   } pse_tgt_state_t;

   typedef struct packed {
      logic busy;      // Between a start and the following stop.
      logic addr_hit;  // One-cycle pulse when the address byte matched.
   } pse_i2c_status_t;

endpackage

// *** hw/pse_i2c_tgt.sv ***
// Serial target front end: start/stop tracking, address match and acknowledge drive.
`timescale 1ns/1ps
module pse_i2c_tgt (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   input  wire logic                      i_scl,
   input  wire logic                      i_sda,
   input  wire logic [pse_pkg::ADDR_W-1:0] i_addr,
   output logic                           o_sda_out,
   output logic                           o_sda_oe,
   output pse_pkg::pse_i2c_status_t       o_status
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] scl_q;
   logic [2:0] sda_q;

   // Stage 0 feeds only stage 1; stages 1 and 2 give the edge view.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda};
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // Data moving while the clock is high marks a start or a stop.
   assign scl_rise  = scl_q[1] & ~scl_q[2];
   assign scl_fall  = ~scl_q[1] & scl_q[2];
   assign bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign bus_stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

   // ------------------------------------------------------------
   // Address phase
   // ------------------------------------------------------------
   pse_pkg::pse_tgt_state_t state_q;
   logic [3:0]              bit_cnt_q;
   logic [7:0]              shift_q;
   logic                    ack_oe_q;
   logic                    hit_q;
   logic [7:0]              byte_now;

   assign byte_now = {shift_q[6:0], sda_q[1]};

   // Only the address byte is acknowledged; later bytes are left alone
   // because this block carries no register map of its own.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q   <= pse_pkg::PSE_TGT_IDLE;
         bit_cnt_q <= pse_pkg::BIT_CNT_RST;
         shift_q   <= 8'h00;
         ack_oe_q  <= 1'b0;
         hit_q     <= 1'b0;
      end else begin
         hit_q <= 1'b0;
         if (bus_stop) begin
            state_q  <= pse_pkg::PSE_TGT_IDLE;
            ack_oe_q <= 1'b0;
         end else if (bus_start) begin
            state_q   <= pse_pkg::PSE_TGT_ADDR;
            bit_cnt_q <= pse_pkg::BIT_CNT_RST;
            ack_oe_q  <= 1'b0;
         end else begin
            case (state_q)
               pse_pkg::PSE_TGT_ADDR: begin
                  if (scl_rise) begin
                     shift_q   <= byte_now;
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == pse_pkg::BIT_CNT_LAST) begin
                        if (byte_now[7:1] == i_addr) begin
                           state_q <= pse_pkg::PSE_TGT_ACK;
                           hit_q   <= 1'b1;
                        end else begin
                           state_q <= pse_pkg::PSE_TGT_HOLD;
                        end
                     end
                  end
               end
               pse_pkg::PSE_TGT_ACK: begin
                  // Drive low from the eighth falling edge to the ninth.
                  if (scl_fall) begin
                     ack_oe_q <= ~ack_oe_q;
                     if (ack_oe_q) begin
                        state_q <= pse_pkg::PSE_TGT_HOLD;
                     end
                  end
               end
               pse_pkg::PSE_TGT_HOLD: state_q <= pse_pkg::PSE_TGT_HOLD;
               pse_pkg::PSE_TGT_IDLE: state_q <= pse_pkg::PSE_TGT_IDLE;
               default:               state_q <= pse_pkg::PSE_TGT_IDLE;
            endcase
         end
      end
   end

   // Open-drain: the line is only ever pulled low.
   assign o_sda_out         = 1'b0;
   assign o_sda_oe          = ack_oe_q;
   assign o_status.busy     = (state_q != pse_pkg::PSE_TGT_IDLE);
   assign o_status.addr_hit = hit_q;

endmodule // pse_i2c_tgt

// *** hw/pse_host_ctrl.sv ***
// Host-facing control pins of a quad-port PoE controller: address straps, reset, alert and over-supply.
`timescale 1ns/1ps
module pse_host_ctrl (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_scl,
   input  wire logic                          i_sda,
   output logic                               o_sda_out,
   output logic                               o_sda_oe,
   input  wire logic                          i_addr_strap_low,
   input  wire logic                          i_addr_strap_mid,
   input  wire logic                          i_addr_strap_high,
   input  wire logic                          i_poe_supply_rail_ok,
   input  wire logic                          i_over_supply,
   input  wire logic [pse_pkg::NUM_PORTS-1:0] i_low_prio,
   input  wire logic [pse_pkg::NUM_PORTS-1:0] i_port_fault,
   output logic [pse_pkg::ADDR_W-1:0]         o_target_addr,
   output logic                               o_ctrl_halt,
   output logic [pse_pkg::NUM_PORTS-1:0]      o_port_force_off,
   output logic [pse_pkg::NUM_PORTS-1:0]      o_port_shed,
   output logic                               o_fault_alert_n_out,
   output logic                               o_fault_alert_oe
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rst_q;
   logic       rst_n;

   // Assertion is immediate, release is synchronous to avoid a ragged exit.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   assign rst_n = rst_q[1];

   // Held low, the controller stops and every port is forced off.
   assign o_ctrl_halt      = ~rst_n;
   assign o_port_force_off = {pse_pkg::NUM_PORTS{~rst_n}};

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;
   logic [2:0] supply_q;
   logic [2:0] oss_q;

   // Straps are static, so their stages carry no reset.
   always_ff @(posedge i_clk) begin
      strap_s1_q <= {i_addr_strap_high, i_addr_strap_mid, i_addr_strap_low};
      strap_s2_q <= strap_s1_q;
   end

   // Both pins idle high, so their stages reset high to avoid a false edge after
   // release; a rail that is still low at release only shows a harmless fall.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_q <= 3'h7;
         oss_q    <= 3'h7;
      end else begin
         supply_q <= {supply_q[1:0], i_poe_supply_rail_ok};
         oss_q    <= {oss_q[1:0], i_over_supply};
      end
   end

   // ------------------------------------------------------------
   // Address capture
   // ------------------------------------------------------------
   logic                        armed_q;
   logic                        capture;
   logic [pse_pkg::ADDR_W-1:0]  addr_q;

   // Capture on the first cycle after release and on each supply rise.
   assign capture = ~armed_q | (supply_q[1] & ~supply_q[2]);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
         addr_q  <= pse_pkg::ADDR_RST;
      end else begin
         armed_q <= 1'b1;
         if (capture) begin
            addr_q <= {pse_pkg::ADDR_PREFIX, strap_s2_q};
         end
      end
   end

   assign o_target_addr = addr_q;

   // ------------------------------------------------------------
   // Serial target
   // ------------------------------------------------------------
   pse_pkg::pse_i2c_status_t bus_stat;

   pse_i2c_tgt u_tgt (
      .i_clk     (i_clk),
      .i_rst_n   (rst_n),
      .i_scl     (i_scl),
      .i_sda     (i_sda),
      .i_addr    (addr_q),
      .o_sda_out (o_sda_out),
      .o_sda_oe  (o_sda_oe),
      .o_status  (bus_stat)
   );

   // ------------------------------------------------------------
   // Emergency shedding
   // ------------------------------------------------------------
   logic                          oss_rise;
   logic [pse_pkg::NUM_PORTS-1:0] shed_q;

   assign oss_rise = oss_q[1] & ~oss_q[2];

   // One-cycle shed request per low-priority port; others are untouched.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         shed_q <= '0;
      end else begin
         shed_q <= oss_rise ? i_low_prio : '0;
      end
   end

   assign o_port_shed = shed_q;

   // ------------------------------------------------------------
   // Fault alert
   // ------------------------------------------------------------
   logic fault_pending;
   logic alert_q;

   assign fault_pending = |i_port_fault;

   // Updating only while the bus is idle keeps the level steady across a
   // transaction; the cost is an alert delayed until the stop.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         alert_q <= 1'b0;
      end else if (!bus_stat.busy) begin
         alert_q <= fault_pending;
      end
   end

   assign o_fault_alert_n_out = 1'b0;
   assign o_fault_alert_oe    = alert_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   a_addr_prefix: assert property (o_target_addr[6:3] == pse_pkg::ADDR_PREFIX)
      else $error("Target address prefix is wrong.");

   a_addr_straps: assert property ($past(capture) && $past(rst_n) |-> o_target_addr[2:0] == $past(strap_s2_q))
      else $error("Target address does not carry the strap levels.");

   a_addr_hold: assert property (!$stable(o_target_addr) |-> $past(capture))
      else $error("Target address changed without a capture event.");

   a_shed_lowprio: assert property (oss_q[1] && !oss_q[2] |=> o_port_shed == $past(i_low_prio))
      else $error("Over-supply edge did not shed the low-priority ports.");

   a_shed_only_edge: assert property (!$past(oss_rise) |-> o_port_shed == '0)
      else $error("Ports shed without an over-supply edge.");

   a_reset_ports_off: assert property (@(posedge i_clk) disable iff (1'b0)
      !rst_n |-> o_ctrl_halt && o_port_force_off == '1 && o_port_shed == '0)
      else $error("Ports not held off during reset.");

   a_alert_fault: assert property (fault_pending && !bus_stat.busy |=> o_fault_alert_oe)
      else $error("Alert not pulled low on a port fault.");

   a_alert_stable: assert property (bus_stat.busy ##1 bus_stat.busy |-> $stable(o_fault_alert_oe))
      else $error("Alert changed during a bus transaction.");

   a_alert_release: assert property (!fault_pending && !bus_stat.busy |=> !o_fault_alert_oe)
      else $error("Alert still low with no fault pending.");

   a_ack_follows: assert property (bus_stat.addr_hit |-> ##[1:200] o_sda_oe)
      else $error("Matched address not acknowledged.");

   c_addr_hit:    cover property (bus_stat.addr_hit);
   c_shed:        cover property (oss_rise ##1 (o_port_shed != '0));
   c_alert_delay: cover property (bus_stat.busy && fault_pending ##1 !bus_stat.busy ##1 o_fault_alert_oe);

endmodule // pse_host_ctrl

// *** verif/pse_host_model.sv ***
// Host processor model that masters the serial bus towards the control block.
`timescale 1ns/1ps
module pse_host_model #(
   parameter real HALF_NS = 62.5  // Half of the 125 ns link clock period.
) (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   // Clock stands high between frames and data is left to its pull-up.
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   // Data moves only mid-way through the low phase, so no false start or stop appears.
   // The link clock runs free of the system clock, as it does on a real board.
   task automatic put_bit(input logic b, output logic seen);
      #(HALF_NS / 2);
      o_sda_oe <= ~b;
      #(HALF_NS / 2);
      o_scl <= 1'b1;
      #(HALF_NS);
      seen = i_sda;
      o_scl <= 1'b0;
   endtask

   // A start pulls data low while the clock is high; the clock then drops.
   // Returning on a system clock edge lets the caller drive its inputs there.
   task automatic start();
      o_sda_oe <= 1'b1;
      #(HALF_NS);
      o_scl <= 1'b0;
      @(posedge i_clk);
   endtask

   // Eight bits most significant first, then a released ninth bit read as acknowledge.
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask

   // A stop releases data while the clock is high and leaves the bus idle.
   task automatic stop();
      #(HALF_NS / 2);
      o_sda_oe <= 1'b1;
      #(HALF_NS / 2);
      o_scl <= 1'b1;
      #(HALF_NS);
      o_sda_oe <= 1'b0;
      #(HALF_NS);
      @(posedge i_clk);
   endtask
endmodule // pse_host_model

// *** verif/tb_pse_host_ctrl.sv ***
// Self-checking testbench for the host-facing control pins block.
`timescale 1ns/1ps
module tb_pse_host_ctrl;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic       i_clk       = 1'b0;
   logic       i_rst_n     = 1'b0;
   logic [2:0] straps      = 3'b101;
   logic       rail_ok     = 1'b1;
   logic       over_supply = 1'b1;
   logic [3:0] low_prio    = 4'h0;
   logic [3:0] port_fault  = 4'h0;
   logic       scl, host_oe, sda_oe, sda_out, sda_w, halt, alert_n, alert_oe;
   logic [6:0] target_addr;
   logic [3:0] force_off, shed;
   int         n_mismatch  = 0;
   int         checked     = 0;

   always #5 i_clk = ~i_clk;

   // The data wire has a pull-up; an enabled driver puts its output level on it.
   assign sda_w = host_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);

   pse_host_ctrl pse_host_ctrl_i (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_w),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_addr_strap_low(straps[0]), .i_addr_strap_mid(straps[1]), .i_addr_strap_high(straps[2]),
      .i_poe_supply_rail_ok(rail_ok), .i_over_supply(over_supply),
      .i_low_prio(low_prio), .i_port_fault(port_fault),
      .o_target_addr(target_addr), .o_ctrl_halt(halt), .o_port_force_off(force_off),
      .o_port_shed(shed), .o_fault_alert_n_out(alert_n), .o_fault_alert_oe(alert_oe)
   );

   pse_host_model pse_host_model_i (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_oe(host_oe));

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One whole frame: start, the address byte, optionally one data byte, stop.
   task automatic frame(input logic [7:0] b, input logic exp_ack, input logic with_data);
      logic ack;
      pse_host_model_i.start();
      pse_host_model_i.send_byte(b, ack);
      cmp(8'(ack), 8'(exp_ack));
      if (with_data) begin
         pse_host_model_i.send_byte(8'h5a, ack);
         cmp(8'(ack), 8'h00);
      end
      pse_host_model_i.stop();
   endtask

   // Raise the over-supply pin and catch the one-cycle shed pulse; a fall must shed nothing.
   task automatic shed_edge(input logic [3:0] mask);
      int k;
      low_prio    <= mask;
      over_supply <= 1'b0;
      tick(4);
      repeat (8) begin
         cmp(8'(shed), 8'h00);
         tick(1);
      end
      over_supply <= 1'b1;
      for (k = 0; k < 8 && shed === 4'h0; k++) begin
         tick(1);
      end
      cmp(8'(shed), 8'(mask));
      tick(1);
      cmp(8'(shed), 8'h00);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_strap_capture();
      cmp(8'(target_addr), {1'b0, pse_pkg::ADDR_PREFIX, 3'b101});
      straps <= 3'b010;
      tick(10);
      cmp(8'(target_addr), {1'b0, pse_pkg::ADDR_PREFIX, 3'b101});
      for (int c = 0; c < 8; c++) begin
         straps  <= c[2:0];
         rail_ok <= 1'b0;
         tick(4);
         rail_ok <= 1'b1;
         tick(8);
         cmp(8'(target_addr), {1'b0, pse_pkg::ADDR_PREFIX, c[2:0]});
      end
   endtask

   // Matching address with both directions, a data byte after it, and two foreign addresses.
   task automatic t_bus_address();
      frame({7'h27, 1'b0}, 1'b1, 1'b1);
      frame({7'h27, 1'b1}, 1'b1, 1'b0);
      frame({7'h26, 1'b0}, 1'b0, 1'b0);
      frame({7'h67, 1'b0}, 1'b0, 1'b0);
   endtask

   task automatic t_shed();
      shed_edge(4'ha);
      shed_edge(4'h5);
   endtask

   // The alert follows the faults while idle and is frozen from start to stop.
   task automatic t_alert();
      port_fault <= 4'h4;
      tick(4);
      cmp(8'(alert_oe), 8'h01);
      cmp(8'(alert_oe ? alert_n : 1'b1), 8'h00);
      port_fault <= 4'h0;
      tick(4);
      cmp(8'(alert_oe), 8'h00);
      pse_host_model_i.start();
      port_fault <= 4'h1;
      tick(20);
      cmp(8'(alert_oe), 8'h00);
      pse_host_model_i.stop();
      tick(2);
      cmp(8'(alert_oe), 8'h01);
   endtask

   // A mid-run reset with a fault pending clears everything and recaptures the straps.
   task automatic t_hard_reset();
      i_rst_n <= 1'b0;
      tick(2);
      cmp(8'(halt), 8'h01);
      cmp(8'(force_off), 8'h0f);
      cmp(8'(alert_oe), 8'h00);
      cmp(8'(shed), 8'h00);
      cmp(8'(sda_oe), 8'h00);
      cmp(8'(target_addr), 8'h20);
      straps <= 3'b011;
      tick(1000);
      i_rst_n <= 1'b1;
      tick(6);
      cmp(8'(halt), 8'h00);
      cmp(8'(force_off), 8'h00);
      cmp(8'(target_addr), 8'h23);
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      tick(20);
      i_rst_n <= 1'b1;
      tick(6);
      t_strap_capture();
      t_bus_address();
      t_shed();
      t_alert();
      t_hard_reset();
      tally_and_finish();
   end

   // The whole sequence needs about 1900 cycles, so 200 us means a hang.
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule // tb_pse_host_ctrl
